//--- rtl/wakeup_defines.vh
// constants shared by the wakeup power sequencer files
`ifndef WAKEUP_DEFINES_VH
`define WAKEUP_DEFINES_VH

// ------------------------------------------------------------
// clock and timing
// ------------------------------------------------------------
`define CLK_HZ 40000000
`define CLK_MHZ 40
`define STROBE_OSC_HZ 25000
`define STROBE_OSC_CYC (`CLK_HZ / `STROBE_OSC_HZ)
`define STROBE_EVERY_TICKS 250
`define STROBE_WIDTH_TICKS 2
`define HALF_BIT_NS 10000
`define HALF_BIT_CYC ((`HALF_BIT_NS * `CLK_MHZ) / 1000)
`define WDOG_NS 100000
`define WDOG_CYC ((`WDOG_NS * `CLK_MHZ) / 1000)
`define ACT_EDGES 4
`define OSC_WAIT_UNIT 256

// ------------------------------------------------------------
// wakeup packet layout
// ------------------------------------------------------------
`define START_MARKER 8'hF0
`define COMPANY_BITS 8
`define DEVICE_BITS 24
`define CHANNEL_BITS 12
`define PKT_BITS 44

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_OSC_WAIT 8'h04
`define REG_CLK_OUT 8'h08
`define REG_COMPANY 8'h0C
`define REG_DEVICE 8'h10
`define REG_CHANNEL 8'h14
`define REG_STATUS 8'h18

// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define CTRL_SLEEP_BIT 0
`define CTRL_INT_STROBE_BIT 1
`define STAT_CORRUPT_BIT 8
`define STAT_WDOG_BIT 9
`define OSC_WAIT_RST 8'h40
`define CLK_OUT_RST 6'h00
`define CTRL_RST 2'h2
// arbitrary neutral identity values
`define COMPANY_RST 8'h5A
`define DEVICE_RST 24'h00A5C3

`endif

//--- rtl/strobe_osc.v
// low-rate strobe oscillator producing the internal strobe window
`timescale 1ns/10ps
module strobe_osc (
  input wire clk,
  input wire rst,
  input wire enable,
  output reg strobe
);
`include "wakeup_defines.vh"

  reg [10:0] osc_cnt;
  reg [7:0] tick_cnt;
  localparam integer TICK_LAST = `STROBE_OSC_CYC - 1;
  localparam integer WIN_LAST = `STROBE_EVERY_TICKS - 1;
  localparam integer WIN_TICKS = `STROBE_WIDTH_TICKS;
  wire tick = (osc_cnt == TICK_LAST[10:0]);

  // ------------------------------------------------------------
  // 25 kHz tick, then window every n ticks
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (rst || !enable) begin
      osc_cnt <= 11'h000;
      tick_cnt <= 8'h00;
      strobe <= 1'b0;
    end else begin
      osc_cnt <= tick ? 11'h000 : osc_cnt + 11'h001;
      if (tick) begin
        tick_cnt <= (tick_cnt == WIN_LAST[7:0]) ? 8'h00 : tick_cnt + 8'h01;
        strobe <= (tick_cnt < WIN_TICKS[7:0]);
      end
    end
  end
endmodule

//--- rtl/manch_sampler.v
// half-bit sampler recovering timing from edges of the ook stream
`timescale 1ns/10ps
module manch_sampler (
  input wire clk,
  input wire rst,
  input wire enable,
  input wire data,
  output reg edge_seen,
  output reg half_valid,
  output reg half_bit
);
`include "wakeup_defines.vh"

  reg prev;
  reg [9:0] phase;
  localparam integer HALF_LAST = `HALF_BIT_CYC - 1;
  localparam integer HALF_MID = `HALF_BIT_CYC / 2;
  wire edge_now = (data != prev);

  // ------------------------------------------------------------
  // phase realigned on every edge, sample mid half-bit
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (rst || !enable) begin
      prev <= 1'b0;
      phase <= 10'h000;
      edge_seen <= 1'b0;
      half_valid <= 1'b0;
      half_bit <= 1'b0;
    end else begin
      prev <= data;
      edge_seen <= edge_now;
      if (edge_now || phase == HALF_LAST[9:0]) begin
        phase <= 10'h000;
      end else begin
        phase <= phase + 10'h001;
      end
      half_valid <= (phase == HALF_MID[9:0]) && !edge_now;
      half_bit <= data;
    end
  end
endmodule

//--- rtl/wakeup_sequencer.v
// wakeup controller: strobe, packet decode and core power sequencing
//
// Overview of operation
// - asleep, strobe is external strobe pin OR internal strobe
// - internal strobe comes from a 25 kHz low-rate oscillator
// - manchester activity in the window holds the strobe on
// - then hunt for non-manchester start marker 11110000
// - after the marker, receive one whole packet before deciding
// - any corrupted symbol aborts and powers down the receiver
// - watchdog ends reception when data and recovered clock stop
// - bit timing recovered from stream transitions samples data
// - channel bits go to mac only if company and device ids match
// - 12 bits after device id are the channel setup
// - valid packet: receiver off, core regulators on
// - regulator select 0 enables both regulators, 1 analog only
// - oscillator starts after regulators good, mac after oscillator
// - oscillator startup wait is programmable by software
// - mac reports ready once core power up succeeds, then initialises
// - software command via mac returns to sleep, core power removed
// - wakeup method chosen from base station and strobe pins
// - base station select high keeps core supply on
// - power-on reset initialises every register and flip-flop, ctrl, osc_wait and the ids to nonzero defaults
// - bypass pin powers down oscillator, external clock used
// - system clock divided by 2 to 256 on programmable outputs
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/10ps
module wakeup_sequencer (
  // clock and reset
  input wire REF_CLK_I,
  input wire RST_I,
  // pins
  input wire EXTERNAL_STROBE_PIN_I,
  input wire OOK_DATA_I,
  input wire REGULATOR_COUNT_SELECT_I,
  input wire BASE_STATION_SELECT_I,
  input wire OSC_BYPASS_PIN_I,
  // core status
  input wire REG_GOOD_I,
  input wire MAC_READY_I,
  // register port
  input wire [7:0] ADDR_I,
  input wire [31:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output reg [31:0] RDATA_O,
  // power and clock control
  output reg RX_EN_O,
  output reg VREG_ANALOG_EN_O,
  output reg VREG_DIGITAL_EN_O,
  output reg CRYSTAL_OSCILLATOR_EN_O,
  output reg EXTERNAL_CLOCK_INPUT_SEL_O,
  output reg MAC_EN_O,
  output reg READY_ACK_O,
  output reg [11:0] CHANNEL_O,
  output reg CHANNEL_VALID_O,
  output reg PROG_CLOCK_OUT_A_O,
  output reg PROG_CLOCK_OUT_B_O
);
`include "wakeup_defines.vh"

  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam S_SLEEP = 8'h01;
  localparam S_LISTEN = 8'h02;
  localparam S_HUNT = 8'h04;
  localparam S_RECV = 8'h08;
  localparam S_REG_UP = 8'h10;
  localparam S_OSC_UP = 8'h20;
  localparam S_MAC_UP = 8'h40;
  localparam S_SESSION = 8'h80;
  localparam integer WDOG_LAST = `WDOG_CYC;
  localparam integer ACT_LAST = `ACT_EDGES;
  localparam integer PKT_LAST = `PKT_BITS - 1;
  localparam integer WAIT_UNIT = `OSC_WAIT_UNIT;
  reg [7:0] state;
  reg [7:0] next_state;
  // registers
  reg [1:0] ctrl;
  reg sleep_cmd;
  reg [7:0] osc_wait;
  reg [5:0] clk_out_sel;
  reg [7:0] company_id;
  reg [23:0] device_id;
  reg flag_corrupt;
  reg flag_wdog;
  // receive path, oscillator wait and clock divider
  reg [7:0] hunt_shift;
  reg pair_phase;
  reg first_half;
  reg [43:0] pkt;
  reg [5:0] bit_cnt;
  reg [2:0] act_cnt;
  reg [12:0] wdog_cnt;
  reg [15:0] wait_cnt;
  reg [7:0] div_cnt;
  wire int_strobe;
  wire edge_seen;
  wire half_valid;
  wire half_bit;
  wire sampler_en = (state == S_LISTEN) || (state == S_HUNT) || (state == S_RECV);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // 0 passes a half-rate toggle, n selects divide by 2^(n+1)
  function div_tap;
    input [2:0] sel;
    input [7:0] cnt;
    begin
      div_tap = cnt[sel];
    end
  endfunction

  function reg_hit;
    input [7:0] addr;
    input [7:0] offs;
    begin
      reg_hit = (addr == offs);
    end
  endfunction

  // ------------------------------------------------------------
  // submodules
  // ------------------------------------------------------------
  // dedicated low-rate strobe source
  strobe_osc u_strobe (
    .clk(REF_CLK_I),
    .rst(RST_I),
    .enable(ctrl[`CTRL_INT_STROBE_BIT]),
    .strobe(int_strobe)
  );

  manch_sampler u_sampler (
    .clk(REF_CLK_I),
    .rst(RST_I),
    .enable(sampler_en),
    .data(OOK_DATA_I),
    .edge_seen(edge_seen),
    .half_valid(half_valid),
    .half_bit(half_bit)
  );

  // either strobe source opens a window
  wire strobe = EXTERNAL_STROBE_PIN_I | int_strobe;
  wire wdog_expired = (wdog_cnt == WDOG_LAST[12:0]);
  wire pair_done = half_valid && pair_phase;
  wire pair_bad = pair_done && (first_half == half_bit);
  wire [43:0] pkt_next = {pkt[42:0], first_half};
  wire ids_match = (pkt_next[43:36] == company_id) && (pkt_next[35:12] == device_id);
  wire pkt_last = pair_done && (bit_cnt == PKT_LAST[5:0]);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always @* begin
    next_state = state;
    case (state)
      S_SLEEP: begin
        // base station pin overrides strobed listening
        if (BASE_STATION_SELECT_I) begin
          next_state = S_REG_UP;
        end else if (strobe) begin
          next_state = S_LISTEN;
        end
      end
      S_LISTEN: begin
        // activity keeps strobe held past the window
        if (act_cnt == ACT_LAST[2:0]) begin
          next_state = S_HUNT;
        end else if (!strobe) begin
          next_state = S_SLEEP;
        end
      end
      S_HUNT: begin
        // marker search in the raw half-bit stream
        if (wdog_expired) begin
          next_state = S_SLEEP;
        end else if (half_valid && {hunt_shift[6:0], half_bit} == `START_MARKER) begin
          next_state = S_RECV;
        end
      end
      S_RECV: begin
        // corrupt symbol aborts, lost clock aborts
        if (wdog_expired || pair_bad) begin
          next_state = S_SLEEP;
        end else if (pkt_last) begin
          // decision only after the full packet
          next_state = ids_match ? S_REG_UP : S_SLEEP;
        end
      end
      S_REG_UP: begin
        next_state = REG_GOOD_I ? S_OSC_UP : S_REG_UP;
      end
      S_OSC_UP: begin
        next_state = (wait_cnt == 16'h0000) ? S_MAC_UP : S_OSC_UP;
      end
      S_MAC_UP: begin
        // mac ready after core power up
        next_state = MAC_READY_I ? S_SESSION : S_MAC_UP;
      end
      S_SESSION: begin
        // return to sleep on command; not with base station
        next_state = (sleep_cmd && !BASE_STATION_SELECT_I) ? S_SLEEP : S_SESSION;
      end
      default: begin
        next_state = S_SLEEP;
      end
    endcase
  end

  // ------------------------------------------------------------
  // state and receive datapath
  // ------------------------------------------------------------
  // reset clears everything and puts state in S_SLEEP
  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      state <= S_SLEEP;
      hunt_shift <= 8'h00;
      pair_phase <= 1'b0;
      first_half <= 1'b0;
      pkt <= 44'h000_0000_0000;
      bit_cnt <= 6'h00;
      act_cnt <= 3'h0;
      wdog_cnt <= 13'h0000;
      wait_cnt <= 16'h0000;
    end else begin
      state <= next_state;
      if (state != S_LISTEN) begin
        act_cnt <= 3'h0;
      end else if (edge_seen && act_cnt != ACT_LAST[2:0]) begin
        act_cnt <= act_cnt + 3'h1;
      end
      if (!sampler_en || edge_seen) begin
        wdog_cnt <= 13'h0000;
      end else if (!wdog_expired) begin
        wdog_cnt <= wdog_cnt + 13'h0001;
      end
      if (state == S_HUNT && half_valid) begin
        hunt_shift <= {hunt_shift[6:0], half_bit};
      end else if (state != S_HUNT) begin
        hunt_shift <= 8'h00;
      end
      // halves pair as 10 for one, 01 for zero
      if (state != S_RECV) begin
        pair_phase <= 1'b0;
        bit_cnt <= 6'h00;
      end else if (half_valid) begin
        pair_phase <= ~pair_phase;
        if (!pair_phase) begin
          first_half <= half_bit;
        end else begin
          pkt <= pkt_next;
          bit_cnt <= bit_cnt + 6'h01;
        end
      end
      if (state != S_OSC_UP) begin
        wait_cnt <= {8'h00, osc_wait} * WAIT_UNIT[15:0];
      end else if (wait_cnt != 16'h0000) begin
        wait_cnt <= wait_cnt - 16'h0001;
      end
    end
  end

  // ------------------------------------------------------------
  // power, clock and handshake outputs
  // ------------------------------------------------------------
  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      RX_EN_O <= 1'b0;
      VREG_ANALOG_EN_O <= 1'b0;
      VREG_DIGITAL_EN_O <= 1'b0;
      CRYSTAL_OSCILLATOR_EN_O <= 1'b0;
      EXTERNAL_CLOCK_INPUT_SEL_O <= 1'b0;
      MAC_EN_O <= 1'b0;
      READY_ACK_O <= 1'b0;
      CHANNEL_O <= 12'h000;
      CHANNEL_VALID_O <= 1'b0;
      PROG_CLOCK_OUT_A_O <= 1'b0;
      PROG_CLOCK_OUT_B_O <= 1'b0;
      div_cnt <= 8'h00;
    end else begin
      // receiver off once the packet is accepted
      RX_EN_O <= |next_state[3:1];
      // regulator count from the select pin
      VREG_ANALOG_EN_O <= |next_state[7:4];
      VREG_DIGITAL_EN_O <= (|next_state[7:4]) & ~REGULATOR_COUNT_SELECT_I;
      // bypass keeps the oscillator core down
      CRYSTAL_OSCILLATOR_EN_O <= (|next_state[7:5]) & ~OSC_BYPASS_PIN_I;
      EXTERNAL_CLOCK_INPUT_SEL_O <= OSC_BYPASS_PIN_I;
      MAC_EN_O <= next_state[6] | next_state[7];
      // ack follows ready, so mac holds ready until seen
      READY_ACK_O <= (state == S_SESSION) && MAC_READY_I;
      // channel setup passed only on full id match
      CHANNEL_VALID_O <= (state == S_RECV) && pkt_last && !pair_bad && ids_match;
      if ((state == S_RECV) && pkt_last && !pair_bad && ids_match) begin
        CHANNEL_O <= pkt_next[11:0];
      end
      // divided clocks from the system clock
      div_cnt <= div_cnt + 8'h01;
      PROG_CLOCK_OUT_A_O <= div_tap(clk_out_sel[2:0], div_cnt);
      PROG_CLOCK_OUT_B_O <= div_tap(clk_out_sel[5:3], div_cnt);
    end
  end

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  wire abort_corrupt = (state == S_RECV) && pair_bad;
  wire abort_wdog = sampler_en && (state != S_LISTEN) && wdog_expired;

  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      ctrl <= `CTRL_RST;
      sleep_cmd <= 1'b0;
      osc_wait <= `OSC_WAIT_RST;
      clk_out_sel <= `CLK_OUT_RST;
      company_id <= `COMPANY_RST;
      device_id <= `DEVICE_RST;
      flag_corrupt <= 1'b0;
      flag_wdog <= 1'b0;
      RDATA_O <= 32'h0000_0000;
    end else begin
      // one-cycle command; ignored outside a session
      sleep_cmd <= WR_I && reg_hit(ADDR_I, `REG_CTRL) && WDATA_I[`CTRL_SLEEP_BIT] &&
                   (state == S_SESSION);
      if (WR_I) begin
        case (ADDR_I)
          `REG_CTRL: ctrl[1] <= WDATA_I[`CTRL_INT_STROBE_BIT];
          `REG_OSC_WAIT: osc_wait <= WDATA_I[7:0];
          `REG_CLK_OUT: clk_out_sel <= WDATA_I[5:0];
          `REG_COMPANY: company_id <= WDATA_I[7:0];
          `REG_DEVICE: device_id <= WDATA_I[23:0];
          default: ;
        endcase
      end
      // sticky abort flags; a new event beats a write-one clear
      if (abort_corrupt) begin
        flag_corrupt <= 1'b1;
      end else if (WR_I && reg_hit(ADDR_I, `REG_STATUS) && WDATA_I[`STAT_CORRUPT_BIT]) begin
        flag_corrupt <= 1'b0;
      end
      if (abort_wdog) begin
        flag_wdog <= 1'b1;
      end else if (WR_I && reg_hit(ADDR_I, `REG_STATUS) && WDATA_I[`STAT_WDOG_BIT]) begin
        flag_wdog <= 1'b0;
      end
      RDATA_O <= 32'h0000_0000;
      if (RD_I) begin
        case (ADDR_I)
          `REG_CTRL: RDATA_O <= {30'h0000_0000, ctrl[1], 1'b0};
          `REG_OSC_WAIT: RDATA_O <= {24'h00_0000, osc_wait};
          `REG_CLK_OUT: RDATA_O <= {26'h000_0000, clk_out_sel};
          `REG_COMPANY: RDATA_O <= {24'h00_0000, company_id};
          `REG_DEVICE: RDATA_O <= {8'h00, device_id};
          `REG_CHANNEL: RDATA_O <= {20'h0_0000, CHANNEL_O};
          `REG_STATUS: RDATA_O <= {22'h00_0000, flag_wdog, flag_corrupt, state};
          default: RDATA_O <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

//--- tb/wakeup_props.sv
// concurrent checks on the wakeup sequencer ports
`timescale 1ns/10ps
module wakeup_props (
  // clock and reset
  input wire REF_CLK_I,
  input wire RST_I,
  // pins and status
  input wire EXTERNAL_STROBE_PIN_I,
  input wire OOK_DATA_I,
  input wire REGULATOR_COUNT_SELECT_I,
  input wire BASE_STATION_SELECT_I,
  input wire OSC_BYPASS_PIN_I,
  input wire REG_GOOD_I,
  input wire MAC_READY_I,
  // outputs
  input wire RX_EN_O,
  input wire VREG_ANALOG_EN_O,
  input wire VREG_DIGITAL_EN_O,
  input wire CRYSTAL_OSCILLATOR_EN_O,
  input wire EXTERNAL_CLOCK_INPUT_SEL_O,
  input wire MAC_EN_O,
  input wire READY_ACK_O,
  input wire CHANNEL_VALID_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  // cycles since the last data edge while receiving without a strobe
  logic [12:0] quiet;
  always @(posedge REF_CLK_I) begin
    if (RST_I || !RX_EN_O || EXTERNAL_STROBE_PIN_I || OOK_DATA_I != $past(OOK_DATA_I))
      quiet <= 13'h0;
    else
      quiet <= quiet + 13'h1;
  end
  property p_strobe_or;
    $rose(EXTERNAL_STROBE_PIN_I) && !RX_EN_O && !VREG_ANALOG_EN_O && !BASE_STATION_SELECT_I
      |-> ##[1:3] RX_EN_O;
  endproperty
  a_strobe_or: assert property (p_strobe_or) else $error("strobe did not open window");
  property p_wdog;
    quiet <= 13'd4010;
  endproperty
  a_wdog: assert property (p_wdog) else $error("receiver kept on without data");
  property p_rx_vs_core;
    RX_EN_O |-> !VREG_ANALOG_EN_O && !MAC_EN_O;
  endproperty
  a_rx_vs_core: assert property (p_rx_vs_core) else $error("receiver and core both on");
  property p_valid;
    CHANNEL_VALID_O |-> !RX_EN_O && VREG_ANALOG_EN_O ##1 !CHANNEL_VALID_O;
  endproperty
  a_valid: assert property (p_valid) else $error("channel valid without power up");
  property p_digital;
    VREG_DIGITAL_EN_O |-> VREG_ANALOG_EN_O && !$past(REGULATOR_COUNT_SELECT_I);
  endproperty
  a_digital: assert property (p_digital) else $error("digital regulator on wrongly");
  property p_xo_after_reg;
    $rose(CRYSTAL_OSCILLATOR_EN_O) |-> VREG_ANALOG_EN_O && $past(REG_GOOD_I);
  endproperty
  a_xo_after_reg: assert property (p_xo_after_reg) else $error("oscillator before regs");
  property p_mac_after_xo;
    $rose(MAC_EN_O) |-> $past(CRYSTAL_OSCILLATOR_EN_O || EXTERNAL_CLOCK_INPUT_SEL_O);
  endproperty
  a_mac_after_xo: assert property (p_mac_after_xo) else $error("mac before oscillator");
  property p_base_hold;
    $past(BASE_STATION_SELECT_I) && $past(VREG_ANALOG_EN_O) |-> VREG_ANALOG_EN_O;
  endproperty
  a_base_hold: assert property (p_base_hold) else $error("supply dropped in base mode");
  property p_bypass;
    $past(OSC_BYPASS_PIN_I) && $past(!RST_I)
      |-> EXTERNAL_CLOCK_INPUT_SEL_O && !CRYSTAL_OSCILLATOR_EN_O;
  endproperty
  a_bypass: assert property (p_bypass) else $error("oscillator on while bypassed");
  property p_ack;
    MAC_READY_I && MAC_EN_O |-> ##[1:2] READY_ACK_O;
  endproperty
  a_ack: assert property (p_ack) else $error("ready not acknowledged");
  c_valid: cover property (CHANNEL_VALID_O);
  c_ack: cover property (READY_ACK_O);
  c_abort: cover property ($fell(RX_EN_O) && !VREG_ANALOG_EN_O);
endmodule
bind wakeup_sequencer wakeup_props u_props (.*);

//--- tb/ook_tx.sv
// base station wakeup transmitter model on the ook data line
`timescale 1ns/10ps
module ook_tx #(parameter HALF = 400) (
  input wire clk,
  output reg data
);
  initial data = 1'b0;
  task automatic half(input logic v);
    begin
      data <= v;
      repeat (HALF) @(posedge clk);
    end
  endtask
  // preamble, nm marker halves, nb bits; bad spoils the last bit
  task automatic send(input logic [43:0] pkt, input int nm, input int nb, input logic bad);
    int i;
    begin
      for (i = 0; i < 6; i++)
        half(!i[0]);
      for (i = 0; i < nm; i++)
        half(i < 4);
      for (i = 0; i < nb; i++) begin
        // one as 10, zero as 01
        half(pkt[43 - i]);
        half((bad && i == nb - 1) ? pkt[43 - i] : !pkt[43 - i]);
      end
      // no carrier after the frame, so no edges either
      data <= 1'b0;
    end
  endtask
endmodule

//--- tb/wakeup_sequencer_test.sv
// self-checking bench for the wakeup power sequencer
`timescale 1ns/10ps
module wakeup_sequencer_test;
  logic REF_CLK_I = 0, RST_I = 1, EXTERNAL_STROBE_PIN_I = 0, REGULATOR_COUNT_SELECT_I = 0;
  logic BASE_STATION_SELECT_I = 0, OSC_BYPASS_PIN_I = 0, REG_GOOD_I = 0, MAC_READY_I = 0;
  logic [7:0] ADDR_I = 8'h00;
  logic [31:0] WDATA_I = 32'h0, RDATA_O, d;
  logic WR_I = 0, RD_I = 0, OOK_DATA_I, RX_EN_O, VREG_ANALOG_EN_O, VREG_DIGITAL_EN_O;
  logic CRYSTAL_OSCILLATOR_EN_O, EXTERNAL_CLOCK_INPUT_SEL_O, MAC_EN_O, READY_ACK_O;
  logic CHANNEL_VALID_O, PROG_CLOCK_OUT_A_O, PROG_CLOCK_OUT_B_O, pa, pb;
  logic [11:0] CHANNEL_O;
  int fails = 0, checks = 0, nvalid = 0, n, ra, rb;
  localparam logic [43:0] PKT = {8'h5A, 24'h00A5C3, 12'hABC};
  logic [7:0] ra_addr [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'hFC};
  logic [31:0] ra_exp [8] = '{32'h2, 32'h40, 32'h0, 32'h5A, 32'hA5C3, 32'h0, 32'h1, 32'h0};
  wakeup_sequencer DUT (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I),
    .EXTERNAL_STROBE_PIN_I(EXTERNAL_STROBE_PIN_I), .OOK_DATA_I(OOK_DATA_I),
    .REGULATOR_COUNT_SELECT_I(REGULATOR_COUNT_SELECT_I),
    .BASE_STATION_SELECT_I(BASE_STATION_SELECT_I), .OSC_BYPASS_PIN_I(OSC_BYPASS_PIN_I),
    .REG_GOOD_I(REG_GOOD_I), .MAC_READY_I(MAC_READY_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .RX_EN_O(RX_EN_O),
    .VREG_ANALOG_EN_O(VREG_ANALOG_EN_O), .VREG_DIGITAL_EN_O(VREG_DIGITAL_EN_O),
    .CRYSTAL_OSCILLATOR_EN_O(CRYSTAL_OSCILLATOR_EN_O),
    .EXTERNAL_CLOCK_INPUT_SEL_O(EXTERNAL_CLOCK_INPUT_SEL_O), .MAC_EN_O(MAC_EN_O),
    .READY_ACK_O(READY_ACK_O), .CHANNEL_O(CHANNEL_O), .CHANNEL_VALID_O(CHANNEL_VALID_O),
    .PROG_CLOCK_OUT_A_O(PROG_CLOCK_OUT_A_O), .PROG_CLOCK_OUT_B_O(PROG_CLOCK_OUT_B_O));
  ook_tx u_tx (.clk(REF_CLK_I), .data(OOK_DATA_I));
  initial begin
    forever #12.5 REF_CLK_I = ~REF_CLK_I;
  end
  always @(posedge REF_CLK_I) if (CHANNEL_VALID_O === 1'b1) nvalid <= nvalid + 1;
  task automatic tick(input int c);
    begin
      repeat (c) @(posedge REF_CLK_I);
      #1;
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      checks++;
      if (got !== exp) begin
        fails++;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    begin
      @(posedge REF_CLK_I);
      WR_I <= 1'b1; ADDR_I <= a; WDATA_I <= v;
      @(posedge REF_CLK_I);
      WR_I <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    begin
      @(posedge REF_CLK_I);
      RD_I <= 1'b1; ADDR_I <= a;
      @(posedge REF_CLK_I);
      RD_I <= 1'b0;
      #1 v = RDATA_O;
    end
  endtask
  // strobe window opened by the pin, dropped once activity is under way
  task automatic frame(input int nm, input int nb, input logic bad);
    begin
      tick(1);
      EXTERNAL_STROBE_PIN_I <= 1'b1;
      fork
        u_tx.send(PKT, nm, nb, bad);
        begin
          tick(2400);
          EXTERNAL_STROBE_PIN_I <= 1'b0;
          chkb(RX_EN_O, 1'b1);
        end
      join
      tick(1);
    end
  endtask
  task automatic end_sim;
    begin
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    #2500000;
    fails++;
    end_sim;
  end
  initial begin
    tick(8);
    RST_I <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(ra_addr[i], d);
      chk(d, ra_exp[i]);
    end
    // internal strobe is on from reset: first window one 25 kHz tick later
    tick(1700);
    chkb(RX_EN_O, 1'b1);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h1);
    // clock outputs: a divides by 2, b by 8
    wr(8'h08, 32'h10);
    tick(4);
    chkb(RX_EN_O, 1'b0);
    ra = 0; rb = 0; pa = PROG_CLOCK_OUT_A_O; pb = PROG_CLOCK_OUT_B_O;
    repeat (64) begin
      tick(1);
      ra += (PROG_CLOCK_OUT_A_O && !pa); rb += (PROG_CLOCK_OUT_B_O && !pb);
      pa = PROG_CLOCK_OUT_A_O; pb = PROG_CLOCK_OUT_B_O;
    end
    chk(ra, 32);
    chk(rb, 8);
    frame(8, 2, 1'b1);
    chkb(RX_EN_O, 1'b0);
    rd(8'h18, d);
    chk(d, 32'h101);
    wr(8'h18, 32'h100);
    frame(0, 0, 1'b0);
    tick(3400);
    chkb(RX_EN_O, 1'b1);
    tick(400);
    chkb(RX_EN_O, 1'b0);
    rd(8'h18, d);
    chk(d, 32'h201);
    wr(8'h18, 32'h200);
    frame(8, 44, 1'b0);
    chk(nvalid, 1);
    chk({20'h0, CHANNEL_O}, 32'hABC);
    chk({RX_EN_O, VREG_ANALOG_EN_O, VREG_DIGITAL_EN_O, CRYSTAL_OSCILLATOR_EN_O}, 32'h6);
    REG_GOOD_I <= 1'b1;
    for (n = 0; n < 20 && CRYSTAL_OSCILLATOR_EN_O !== 1'b1; n++) tick(1);
    for (n = 0; n < 400 && MAC_EN_O !== 1'b1; n++) tick(1);
    // one wait unit of 256 cycles, a little pipeline slack
    chkb(n >= 255 && n <= 258, 1'b1);
    MAC_READY_I <= 1'b1;
    for (n = 0; n < 20 && READY_ACK_O !== 1'b1; n++) tick(1);
    MAC_READY_I <= 1'b0;
    chkb(READY_ACK_O, 1'b1);
    rd(8'h18, d);
    chk(d, 32'h80);
    wr(8'h00, 32'h1);
    REG_GOOD_I <= 1'b0;
    tick(3);
    chk({VREG_ANALOG_EN_O, CRYSTAL_OSCILLATOR_EN_O, MAC_EN_O}, 32'h0);
    wr(8'h10, 32'hA5C4);
    frame(8, 44, 1'b0);
    chk(nvalid, 1);
    chk({RX_EN_O, VREG_ANALOG_EN_O}, 32'h0);
    BASE_STATION_SELECT_I <= 1'b1;
    REGULATOR_COUNT_SELECT_I <= 1'b1;
    OSC_BYPASS_PIN_I <= 1'b1;
    tick(4);
    chk({VREG_ANALOG_EN_O, VREG_DIGITAL_EN_O}, 32'h2);
    REG_GOOD_I <= 1'b1;
    tick(4);
    chk({CRYSTAL_OSCILLATOR_EN_O, EXTERNAL_CLOCK_INPUT_SEL_O}, 32'h1);
    tick(300);
    MAC_READY_I <= 1'b1;
    for (n = 0; n < 20 && READY_ACK_O !== 1'b1; n++) tick(1);
    MAC_READY_I <= 1'b0;
    wr(8'h00, 32'h1);
    tick(4);
    chkb(VREG_ANALOG_EN_O, 1'b1);
    rd(8'h18, d);
    chk(d, 32'h80);
    end_sim;
  end
endmodule
